// ==== rtl/ads_defs.svh ====
// Constants of the audio serial back end: offsets, counts and timing figures.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef ADS_DEFS_SVH
`define ADS_DEFS_SVH

// System clock rate in MHz
`define ADS_CLK_MHZ 100
// Master bit clock half period in system cycles (even divide keeps 50 % duty)
`define ADS_BCLK_HALF_CYC 6
// Bit clocks per frame and per channel phase
`define ADS_BITS_PER_FRAME 64
`define ADS_BITS_PER_HALF 32
// Sample width
`define ADS_SAMPLE_W 24
// Group delay per speed mode, in sample periods
`define ADS_DELAY_SINGLE 12
`define ADS_DELAY_DOUBLE 9
`define ADS_DELAY_QUAD 5
`define ADS_DELAY_MAX 12
// Speed select pin codes
`define ADS_SPEED_CODE_SINGLE 2'b00
`define ADS_SPEED_CODE_DOUBLE 2'b01
`define ADS_SPEED_CODE_QUAD 2'b10
// Overflow indicator setup before a frame edge, in bit clocks
`define ADS_OVFL_SETUP_BITS 16
// Overflow time-out per rate family, in ms
`define ADS_OVFL_TO_441_MS 740
`define ADS_OVFL_TO_48_MS 680
// High-pass shift: corner = fs / (2*pi*2^13), about 0.93 Hz at 48 kHz
`define ADS_HPF_SHIFT 13

`endif

// ==== rtl/ads_hpf.sv ====
// First-order DC-blocking high-pass filter, one audio channel.
// Assumes one step per output sample, so the corner tracks the sample rate.
`timescale 1ns/10ps
`default_nettype none
`include "ads_defs.svh"
module ads_hpf
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic step_i,
   input wire ads_pkg::ads_sample_t x_i,
   output ads_pkg::ads_sample_t y_o
);
   import ads_pkg::*;

   logic signed [36:0] acc_r;
   logic signed [23:0] dc;
   logic signed [24:0] diff;

   // Running DC estimate and difference
   assign dc = acc_r[36:13];
   assign diff = {x_i[23], x_i} - {dc[23], dc};

   // DC tracker: dc += (x - dc) / 2^shift per sample
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i || !en_i)
         acc_r <= 37'h0;
      else if (step_i)
         acc_r <= acc_r + {{(37 - 25){diff[24]}}, diff};
   end

   // Saturated output, bypass when disabled
   always_comb
   begin
      if (!en_i)
         y_o = x_i;
      else if (diff[24] != diff[23])
         y_o = diff[24] ? 24'sh800000 : 24'sh7fffff;
      else
         y_o = diff[23:0];
   end
endmodule
`default_nettype wire

// ==== rtl/ads_pkg.sv ====
// Types shared by the audio serial back end.
// Assumes nothing of its surroundings.
package ads_pkg;
   typedef enum logic [1:0] {ADS_SINGLE, ADS_DOUBLE, ADS_QUAD} ads_speed_e;
   typedef logic signed [23:0] ads_sample_t;
endpackage

// ==== rtl/ads_serial_out.sv ====
// Audio converter back end: group delay line, high-pass, overflow flag and serial port.
// Assumes a 100 MHz system clock; link pins come from outside and are synchronised.
// Overview of operation
// - Three speed modes cover 2-54, 50-108 and 100-216 kHz sample rates.
// - Group delay is 12, 9 or 5 sample periods by speed mode.
// - Passband edge 0.47, 0.45, 0.24 of rate; response scales with rate.
// - Optional high-pass has about 1 Hz corner at 48 kHz, scaling with rate.
// - Overflow flag settles 16 bit clocks before, holds one after frame edge.
// - Overflow flag stays set about 740 ms or 680 ms after overrange.
// - In master mode each data bit launches at a bit clock falling edge.
// - In master mode frame clock runs at sample rate, bit clock at 64x.
`timescale 1ns/10ps
`default_nettype none
`include "ads_defs.svh"
module ads_serial_out
#(
   parameter int OVFL_TO_441_CYC = `ADS_OVFL_TO_441_MS * 1000 * `ADS_CLK_MHZ,
   parameter int OVFL_TO_48_CYC = `ADS_OVFL_TO_48_MS * 1000 * `ADS_CLK_MHZ
)
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic speed_select_high_i,
   input wire logic speed_select_low_i,
   input wire logic master_mode_i,
   input wire logic hpf_enable_i,
   input wire logic rate_family_48_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire ads_pkg::ads_sample_t sample_left_i,
   input wire ads_pkg::ads_sample_t sample_right_i,
   input wire logic overrange_i,
   input wire logic bit_clk_i,
   output logic bit_clk_o,
   output logic bit_clk_oe_o,
   input wire logic frame_select_clock_i,
   output logic frame_select_clock_o,
   output logic frame_select_clock_oe_o,
   output logic serial_sample_out_o,
   output logic overflow_flag_n_o
);
   import ads_pkg::*;

   localparam logic [3:0] HALF_LAST = 4'(`ADS_BCLK_HALF_CYC - 1);

   logic [4:0] sy1_r, sy2_r;
   logic [1:0] bclk_sy_r, frm_sy_r;
   logic bclk_d_r, frame_prev_r;
   logic master_s, hpf_en_s, fam48_s;
   ads_speed_e speed;
   logic [3:0] div_r;
   logic m_fall, s_fall, tick, load;
   logic [5:0] bit_cnt_r, nc, lo, idx;
   logic [47:0] word_r, cur;
   logic [3:0] tap;
   ads_sample_t dl_l [0:`ADS_DELAY_MAX-1];
   ads_sample_t dl_r [0:`ADS_DELAY_MAX-1];
   logic [47:0] buf_r [0:1];
   logic wp_r, rp_r;
   logic [1:0] cnt_r;
   logic push, pop;
   ads_sample_t hpf_l, hpf_r;
   logic [31:0] ovfl_tmr_r;

   //------------------------------------------------------------
   // Synchronisers
   //------------------------------------------------------------

   // Two flops on every pin input
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         sy1_r <= 5'h00;
         sy2_r <= 5'h00;
         bclk_sy_r <= 2'h0;
         frm_sy_r <= 2'h0;
      end
      else
      begin
         sy1_r <= {master_mode_i, hpf_enable_i, rate_family_48_i, speed_select_high_i, speed_select_low_i};
         sy2_r <= sy1_r;
         bclk_sy_r <= {bclk_sy_r[0], bit_clk_i};
         frm_sy_r <= {frm_sy_r[0], frame_select_clock_i};
      end
   end

   assign master_s = sy2_r[4];
   assign hpf_en_s = sy2_r[3];
   assign fam48_s = sy2_r[2];

   // Speed decode; reserved code falls back to single speed
   always_comb
   begin
      unique case (sy2_r[1:0])
         `ADS_SPEED_CODE_DOUBLE: speed = ADS_DOUBLE;
         `ADS_SPEED_CODE_QUAD: speed = ADS_QUAD;
         default: speed = ADS_SINGLE;
      endcase
   end

   //------------------------------------------------------------
   // Bit clock timing
   //------------------------------------------------------------

   // Master divider toggles the bit clock every half period
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i || !master_s)
      begin
         div_r <= 4'h0;
         bit_clk_o <= 1'b0;
      end
      else if (div_r == HALF_LAST)
      begin
         div_r <= 4'h0;
         bit_clk_o <= !bit_clk_o;
      end
      else
         div_r <= div_r + 4'h1;
   end

   // Slave edge history, read from second sync flop only
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
         bclk_d_r <= 1'b0;
      else
         bclk_d_r <= bclk_sy_r[1];
   end

   assign m_fall = master_s && (div_r == HALF_LAST) && bit_clk_o;
   assign s_fall = !master_s && bclk_d_r && !bclk_sy_r[1];
   assign tick = m_fall || s_fall;

   // Next bit position; slave realigns on frame clock changes
   always_comb
   begin
      if (!master_s && (frm_sy_r[1] != frame_prev_r))
         nc = frm_sy_r[1] ? 6'h00 : 6'h20;
      else
         nc = bit_cnt_r + 6'h01;
   end

   assign load = tick && (nc == 6'h00);

   // Bit counter, frame clock and output enables
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         bit_cnt_r <= 6'h3f;
         frame_prev_r <= 1'b0;
         frame_select_clock_o <= 1'b0;
         bit_clk_oe_o <= 1'b0;
         frame_select_clock_oe_o <= 1'b0;
      end
      else
      begin
         bit_clk_oe_o <= master_s;
         frame_select_clock_oe_o <= master_s;
         if (tick)
         begin
            bit_cnt_r <= nc;
            frame_prev_r <= frm_sy_r[1];
            frame_select_clock_o <= !nc[5];
         end
      end
   end

   //------------------------------------------------------------
   // Two-entry input buffer
   //------------------------------------------------------------

   assign push = sample_valid_i && sample_ready_o;
   assign pop = load && (cnt_r != 2'h0);

   // Pointers, fill count and registered ready
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
         sample_ready_o <= 1'b0;
         buf_r[0] <= 48'h0;
         buf_r[1] <= 48'h0;
      end
      else
      begin
         if (push)
         begin
            buf_r[wp_r] <= {sample_left_i, sample_right_i};
            wp_r <= !wp_r;
         end
         if (pop)
            rp_r <= !rp_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
         sample_ready_o <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h2;
      end
   end

   //------------------------------------------------------------
   // High-pass and group delay line
   //------------------------------------------------------------

   // One filter per channel, stepped once per sample
   ads_hpf u_hpf_l (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .en_i(hpf_en_s), .step_i(pop),
      .x_i(buf_r[rp_r][47:24]), .y_o(hpf_l));
   ads_hpf u_hpf_r (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .en_i(hpf_en_s), .step_i(pop),
      .x_i(buf_r[rp_r][23:0]), .y_o(hpf_r));

   // Tap per speed mode; decimation response upstream scales with the rate
   always_comb
   begin
      unique case (speed)
         ADS_DOUBLE: tap = 4'(`ADS_DELAY_DOUBLE - 1);
         ADS_QUAD: tap = 4'(`ADS_DELAY_QUAD - 1);
         ADS_SINGLE: tap = 4'(`ADS_DELAY_SINGLE - 1);
      endcase
   end

   // Delay line advances once per frame; empty buffer inserts silence
   // Cleared on reset so the first frames carry silence, not unknowns
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < `ADS_DELAY_MAX; i++)
         begin
            dl_l[i] <= 24'sh000000;
            dl_r[i] <= 24'sh000000;
         end
      end
      else if (load)
      begin
         dl_l[0] <= pop ? hpf_l : 24'sh000000;
         dl_r[0] <= pop ? hpf_r : 24'sh000000;
         for (int i = 1; i < `ADS_DELAY_MAX; i++)
         begin
            dl_l[i] <= dl_l[i-1];
            dl_r[i] <= dl_r[i-1];
         end
      end
   end

   //------------------------------------------------------------
   // Serial shifter
   //------------------------------------------------------------

   // Current word and bit index, MSB first per phase
   always_comb
   begin
      cur = load ? {dl_l[tap], dl_r[tap]} : word_r;
      lo = {1'b0, nc[4:0]};
      idx = nc[5] ? (6'h17 - lo) : (6'h2f - lo);
   end

   // Launch each bit on the bit clock fall
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         word_r <= 48'h0;
         serial_sample_out_o <= 1'b0;
      end
      else if (tick)
      begin
         word_r <= cur;
         serial_sample_out_o <= (nc[4:0] < 5'h18) ? cur[idx] : 1'b0;
      end
   end

   //------------------------------------------------------------
   // Overflow indicator
   //------------------------------------------------------------

   // Time-out restarts on every overrange
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
         ovfl_tmr_r <= 32'h0;
      else if (overrange_i)
         ovfl_tmr_r <= fam48_s ? 32'(OVFL_TO_48_CYC) : 32'(OVFL_TO_441_CYC);
      else if (ovfl_tmr_r != 32'h0)
         ovfl_tmr_r <= ovfl_tmr_r - 32'h1;
   end

   // Flag moves only 16 bit clocks ahead of a frame edge
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
         overflow_flag_n_o <= 1'b1;
      else if (tick && (nc[4:0] == 5'(`ADS_OVFL_SETUP_BITS)))
         overflow_flag_n_o <= (ovfl_tmr_r == 32'h0);
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence s_bclk_high;
      bit_clk_o [*6];
   endsequence
   sequence s_bclk_low;
      !bit_clk_o [*6];
   endsequence

   a_bclk_duty: assert property (master_s && $rose(bit_clk_o) |-> s_bclk_high ##1 s_bclk_low)
      else $error("bit clock duty not even");
   a_data_on_fall: assert property (master_s && $changed(serial_sample_out_o) |-> $fell(bit_clk_o))
      else $error("data changed away from bit clock fall");
   a_frame_edge_pos: assert property (master_s && $changed(frame_select_clock_o) |-> bit_cnt_r[4:0] == 5'h00)
      else $error("frame clock moved off a 32-bit boundary");
   a_ovfl_setup_pos: assert property ($changed(overflow_flag_n_o) |-> bit_cnt_r[4:0] == 5'h10)
      else $error("overflow flag moved too near a frame edge");
   a_ovfl_holds: assert property (overrange_i |=> (ovfl_tmr_r != 32'h0) [*8])
      else $error("overflow time-out not started");
   a_msb_first: assert property (load |=> serial_sample_out_o == word_r[47] && frame_select_clock_o)
      else $error("left MSB not first in frame");
   a_delay_tap: assert property (speed == ADS_QUAD |-> tap == 4'h4)
      else $error("quad speed tap wrong");
   a_rate_modes: assert property (speed == ADS_DOUBLE |-> tap == 4'h8)
      else $error("double speed tap wrong");
   a_hpf_bypass: assert property (!hpf_en_s |-> hpf_l == buf_r[rp_r][47:24])
      else $error("high-pass not bypassed");
   a_buf_full: assert property (cnt_r == 2'h2 |-> !sample_ready_o)
      else $error("ready while buffer full");
endmodule
`default_nettype wire

// ==== test/ads_rx_model.sv ====
// Serial audio receiver model: bit capture, frame and clock measures, slave clocks.
// Assumes the bench resolves the clock and frame wires from both drivers.
`timescale 1ns/10ps
`default_nettype none
module ads_rx_model
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic bclk_i,
   input wire logic fsc_i,
   input wire logic sdo_i,
   output logic bclk_drv_o,
   output logic fsc_drv_o,
   output logic stb_o,
   output logic [47:0] word_o,
   output var int frames_o,
   output var int idx_o,
   output var int bits_o,
   output var int hi_o,
   output var int lo_o
);
   logic bclk_q = 1'b0;
   logic fsc_q = 1'b0;
   logic [22:0] sr = '0;
   int run = 0;
   int bn = 0;
   // Slave clocks: 125 ns bit clock, frame flips on falls, even duty
   initial
   begin
      bclk_drv_o = 1'b0;
      fsc_drv_o = 1'b0;
      forever
      begin
         #62.5;
         bclk_drv_o = ~bclk_drv_o;
         if (!bclk_drv_o)
         begin
            bn = (bn + 1) % 64;
            fsc_drv_o = (bn < 32);
         end
      end
   end
   // Capture on rises, measure high and low times
   always @(posedge clk_sys_i)
   begin
      int i;
      i = idx_o;
      stb_o <= 1'b0;
      bclk_q <= bclk_i;
      run <= run + 1;
      if (!nrst_i)
      begin
         frames_o <= 0;
         idx_o <= 0;
         fsc_q <= 1'b0;
      end
      else if (bclk_i && !bclk_q)
      begin
         lo_o <= run;
         run <= 1;
         fsc_q <= fsc_i;
         if (fsc_i && !fsc_q)
         begin
            frames_o <= frames_o + 1;
            bits_o <= idx_o;
            i = 0;
         end
         sr <= {sr[21:0], sdo_i};
         if (i == 23)
            word_o[47:24] <= {sr, sdo_i};
         if (i == 55)
         begin
            word_o[23:0] <= {sr, sdo_i};
            stb_o <= 1'b1;
         end
         idx_o <= i + 1;
      end
      else if (!bclk_i && bclk_q)
      begin
         hi_o <= run;
         run <= 1;
      end
   end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Bench: master and slave runs of the serial back end against a queue model.
// Assumes ads_rx_model on the link and short overflow time-outs.
`timescale 1ns/10ps
`default_nettype none
`include "ads_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin num_errors++; \
   $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
   import ads_pkg::*;
   localparam int TO_A = 2000;
   localparam int TO_B = 1000;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sph = 1'b0;
   logic spl = 1'b0;
   logic mst = 1'b1;
   logic fam = 1'b0;
   logic vld = 1'b0;
   logic ovr = 1'b0;
   logic push = 1'b0;
   logic seeded = 1'b0;
   logic seen = 1'b0;
   ads_sample_t sl = 24'h1;
   ads_sample_t sr = 24'h1;
   logic rdy, bco, bcoe, fco, fcoe, sdo, flg, bcw, fcw, stb, bdrv, fdrv, sdo_q, bco_q, flg_q;
   logic [47:0] rw;
   logic [47:0] q[$];
   int frames, idx, bits, hi, lo, zeros, hits;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   // --------------------------------
   // Wires, clock, instances
   // --------------------------------
   assign bcw = bcoe ? bco : (!mst ? bdrv : ~bco);
   assign fcw = fcoe ? fco : (!mst ? fdrv : ~fco);
   initial
   begin
      forever #5 clk = ~clk;
   end
   ads_serial_out #(.OVFL_TO_441_CYC(TO_A), .OVFL_TO_48_CYC(TO_B)) ads_serial_out_i
   (
      .clk_sys_i(clk), .nrst_i(nrst), .speed_select_high_i(sph), .speed_select_low_i(spl),
      .master_mode_i(mst), .hpf_enable_i(1'b0), .rate_family_48_i(fam), .sample_valid_i(vld),
      .sample_ready_o(rdy), .sample_left_i(sl), .sample_right_i(sr), .overrange_i(ovr),
      .bit_clk_i(bcw), .bit_clk_o(bco), .bit_clk_oe_o(bcoe), .frame_select_clock_i(fcw),
      .frame_select_clock_o(fco), .frame_select_clock_oe_o(fcoe), .serial_sample_out_o(sdo),
      .overflow_flag_n_o(flg)
   );
   ads_rx_model ads_rx_model_i
   (
      .clk_sys_i(clk), .nrst_i(nrst), .bclk_i(bcw), .fsc_i(fcw), .sdo_i(sdo),
      .bclk_drv_o(bdrv), .fsc_drv_o(fdrv), .stb_o(stb), .word_o(rw), .frames_o(frames),
      .idx_o(idx), .bits_o(bits), .hi_o(hi), .lo_o(lo)
   );
   // Source: random stereo words, held until taken
   always @(posedge clk)
   begin
      if (!seeded)
         void'($urandom(32'h3709a1e8));
      seeded <= 1'b1;
      if (vld && rdy)
      begin
         q.push_back({sl, sr});
         sl <= 24'($urandom) | 24'h1;
         sr <= 24'($urandom) | 24'h1;
      end
      vld <= push;
   end
   // Model: leading silent frames, then words in push order
   always @(posedge clk)
   begin
      logic [47:0] e;
      if (stb && rw === 48'h0 && !seen)
         zeros++;
      else if (stb)
      begin
         e = q.size() > 0 ? q.pop_front() : 'x;
         seen = 1'b1;
         hits++;
         `CHK("sample word", e, rw)
      end
   end
   // Launch edges, overflow change points, hang limit
   always @(posedge clk)
   begin
      sdo_q <= sdo;
      bco_q <= bco;
      flg_q <= flg;
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         num_errors++;
         test_done();
      end
      if (nrst && mst && sdo !== sdo_q)
         `CHK("launch edge", 2'b10, {bco_q, bco})
      if (nrst && flg !== flg_q)
         `CHK("ovfl point", 1'b1, idx == 16 || idx == 48)
   end
   task automatic run(input logic [1:0] code, input logic m, input logic f, input int nf, input int ez);
      int t0;
      int to;
      to = f ? TO_B : TO_A;
      @(posedge clk);
      nrst <= 1'b0;
      {sph, spl} <= code;
      mst <= m;
      fam <= f;
      push <= 1'b0;
      repeat (16) @(posedge clk);
      q.delete();
      zeros = 0;
      hits = 0;
      seen = 1'b0;
      nrst <= 1'b1;
      push <= 1'b1;
      while (frames < 3) @(posedge clk);
      if (m)
      begin
         ovr <= 1'b1;
         @(posedge clk);
         ovr <= 1'b0;
         t0 = cyc;
         while (flg !== 1'b0 && cyc < t0 + 400) @(posedge clk);
         `CHK("ovfl set", 1'b0, flg)
         while (flg !== 1'b1 && cyc < t0 + to + 420) @(posedge clk);
         `CHK("ovfl timeout", 1'b1, flg === 1'b1 && cyc >= t0 + to - 2)
         `CHK("bclk high", `ADS_BCLK_HALF_CYC, hi)
         `CHK("bclk low", `ADS_BCLK_HALF_CYC, lo)
         `CHK("bits per frame", `ADS_BITS_PER_FRAME, bits)
      end
      while (frames < nf) @(posedge clk);
      if (ez >= 0)
         `CHK("delay frames", ez, zeros)
      `CHK("words seen", 1'b1, hits > 2)
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Every speed code, both families, then slave
   initial
   begin
      run(`ADS_SPEED_CODE_SINGLE, 1'b1, 1'b0, 16, `ADS_DELAY_SINGLE);
      run(`ADS_SPEED_CODE_DOUBLE, 1'b1, 1'b1, 13, `ADS_DELAY_DOUBLE);
      run(`ADS_SPEED_CODE_QUAD, 1'b1, 1'b0, 9, `ADS_DELAY_QUAD);
      run(2'b11, 1'b1, 1'b1, 16, `ADS_DELAY_SINGLE);
      run(`ADS_SPEED_CODE_SINGLE, 1'b0, 1'b0, 17, -1);
      test_done();
   end
endmodule
`default_nettype wire
